// [logic/link_regs_map.svh]
`ifndef LINK_REGS_MAP_SVH
`define LINK_REGS_MAP_SVH

// Register offsets on the host register port.
`define OFS_HCC_SET 12'h050
`define OFS_HCC_CLR 12'h054
`define OFS_SELFID_BASE 12'h064

// Windows of registers that are clocked by the PHY-supplied clock.
`define OFS_PHYDOM_A_LO 12'h0DC
`define OFS_PHYDOM_A_HI 12'h0F0
`define OFS_PHYDOM_B_LO 12'h100
`define OFS_PHYDOM_B_HI 12'h11C

// Field positions in the host link control register.
`define HCC_PERMIT_BIT 23
`define HCC_ENHANCE_BIT 22
`define HCC_POWER_STATE_BIT 19
`define HCC_POSTING_BIT 18
`define HCC_LINK_ACTIVE_BIT 17
`define HCC_SOFT_INIT_BIT 16

// Self-ID base: writable bits and alignment.
`define SELFID_BASE_MSB 31
`define SELFID_BASE_LSB 11
`define SELFID_QUAD_LSB 2

// Data returned for a PHY-domain access while that clock is stopped.
`define ALL_ONES_DATA 32'hFFFFFFFF
`define ZERO_DATA 32'h00000000

// Length of the soft initialisation sequence.
`define CLK_PERIOD_NS 100
`define SOFT_INIT_NS 1000
`define SOFT_INIT_CYCLES ((`SOFT_INIT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// [logic/link_regs_pkg.sv]
package link_regs_pkg;

    // One host register access as presented on the register port.
    typedef struct packed {
        logic        wr;
        logic [11:0] addr;
        logic [31:0] wdata;
    } reg_req_t;

    // Control bits of the host link control register held in this block.
    typedef struct packed {
        logic phy_enhance_on;
        logic link_power_state;
        logic write_posting_on;
        logic link_active;
    } hcc_bits_t;

    // Soft initialisation sequencer states, Gray coded along idle-run-done.
    typedef enum logic [1:0] {
        SI_IDLE = 2'b00,
        SI_RUN  = 2'b01,
        SI_DONE = 2'b11
    } soft_init_state_t;

endpackage

// [logic/soft_init_seq.sv]
`timescale 1ns/1ps
`include "link_regs_map.svh"

module soft_init_seq
    import link_regs_pkg::*;
(
    input wire logic i_clk_sys,  // System clock.
    input wire logic i_sys_rst,  // Synchronous reset, active high.
    input wire logic i_start,    // One-cycle request to start.
    output logic o_busy,         // High while the sequence runs.
    output logic o_flush         // One-cycle pulse at the start.
);

    localparam int CNT_W = 8;
    localparam logic [CNT_W-1:0] LAST_CNT = CNT_W'(`SOFT_INIT_CYCLES - 1);

    soft_init_state_t state_r;
    logic [CNT_W-1:0] cnt_r;

    // Sequencer: a start is ignored while a run is already in progress.
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            state_r <= SI_IDLE;
        end else begin
            unique case (state_r)
                SI_IDLE: begin
                    if (i_start) begin
                        state_r <= SI_RUN;
                    end
                end
                SI_RUN: begin
                    if (cnt_r == LAST_CNT) begin
                        state_r <= SI_DONE;
                    end
                end
                SI_DONE: begin
                    state_r <= SI_IDLE;
                end
                default: begin
                    state_r <= SI_IDLE;
                end
            endcase
        end
    end

    // Cycle counter for the run phase.
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst || state_r != SI_RUN) begin
            cnt_r <= '0;
        end else begin
            cnt_r <= cnt_r + 1'b1;
        end
    end

    // Flush fires once as the run begins so every consumer clears together.
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            o_flush <= 1'b0;
        end else begin
            o_flush <= (state_r == SI_IDLE) && i_start;
        end
    end

    assign o_busy = (state_r != SI_IDLE);

endmodule

// [logic/link_host_control_regs.sv]
`timescale 1ns/1ps
`include "link_regs_map.svh"

module link_host_control_regs
    import link_regs_pkg::*;
(
    input wire logic i_clk_sys,              // System clock, 10 MHz.
    input wire logic i_sys_rst,              // Synchronous reset, active high.
    input wire logic i_req_valid,            // Register access request.
    input wire reg_req_t i_req,              // Access address, direction and data.
    output logic o_ack,                      // Access completed normally.
    output logic o_abort,                    // Access ended in target abort.
    output logic [31:0] o_rdata,             // Read data, valid with o_ack.
    input wire logic i_suppress_abort,       // Abort suppression config bit.
    input wire logic i_enhance_cfg_permit,   // Enhancement permit strap pin.
    input wire logic i_phy_clk_alive,        // PHY clock running indication pin.
    input wire logic [8:0] i_selfid_quad,    // Self-ID quadlet index to store.
    output logic [31:0] o_selfid_wr_addr,    // Host address for that quadlet.
    output logic [31:0] o_selfid_base,       // Current self-ID buffer base.
    output logic o_phy_comm_en,              // Link-to-PHY traffic permitted.
    output logic o_bus_connect,              // Node logically on the serial bus.
    output logic o_write_posting_on,         // Posted writes enabled.
    output logic o_phy_enhance_on,           // PHY enhancements in use.
    output logic o_soft_init_flush           // One-cycle flush of all FIFOs and state.
);

    logic permit_s1_r, permit_r;
    logic alive_s1_r, alive_r;
    hcc_bits_t hcc_r;
    logic [`SELFID_BASE_MSB:`SELFID_BASE_LSB] base_r;
    logic si_busy, si_flush;
    logic wr_set, wr_clr, wr_base, si_start;
    logic [31:0] hcc_rd;

    // Address window check shared by the abort path and the read mux.
    function automatic logic in_phy_domain(input logic [11:0] addr);
        return (addr >= `OFS_PHYDOM_A_LO && addr <= `OFS_PHYDOM_A_HI) ||
               (addr >= `OFS_PHYDOM_B_LO && addr <= `OFS_PHYDOM_B_HI);
    endfunction

    // Both pins come from outside the clock domain, so each passes two flops.
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            permit_s1_r <= 1'b0;
            permit_r <= 1'b0;
            alive_s1_r <= 1'b0;
            alive_r <= 1'b0;
        end else begin
            permit_s1_r <= i_enhance_cfg_permit;
            permit_r <= permit_s1_r;
            alive_s1_r <= i_phy_clk_alive;
            alive_r <= alive_s1_r;
        end
    end

    // Write decode of the set and clear aliases and the self-ID pointer.
    // two aliases
    assign wr_set = i_req_valid && i_req.wr && i_req.addr == `OFS_HCC_SET;
    assign wr_clr = i_req_valid && i_req.wr && i_req.addr == `OFS_HCC_CLR;
    assign wr_base = i_req_valid && i_req.wr && i_req.addr == `OFS_SELFID_BASE;
    assign si_start = wr_set && i_req.wdata[`HCC_SOFT_INIT_BIT];

    soft_init_seq u_soft_init (
        .i_clk_sys(i_clk_sys),
        .i_sys_rst(i_sys_rst),
        .i_start(si_start),
        .o_busy(si_busy),
        .o_flush(si_flush)
    );

    // Control bits; the soft-init flush restores them like a hardware reset.
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst || si_flush) begin
            hcc_r <= '0;
        end else begin
            if (wr_set) begin
                if (i_req.wdata[`HCC_ENHANCE_BIT] && permit_r && hcc_r.link_active) begin
                    hcc_r.phy_enhance_on <= 1'b1;
                end
                if (i_req.wdata[`HCC_POWER_STATE_BIT]) begin
                    hcc_r.link_power_state <= 1'b1;
                end
                if (i_req.wdata[`HCC_POSTING_BIT] && !hcc_r.link_active) begin
                    hcc_r.write_posting_on <= 1'b1;
                end
                if (i_req.wdata[`HCC_LINK_ACTIVE_BIT]) begin
                    hcc_r.link_active <= 1'b1;
                end
            end else if (wr_clr) begin
                if (i_req.wdata[`HCC_ENHANCE_BIT] && permit_r) begin
                    hcc_r.phy_enhance_on <= 1'b0;
                end
                if (i_req.wdata[`HCC_POWER_STATE_BIT]) begin
                    hcc_r.link_power_state <= 1'b0;
                end
                if (i_req.wdata[`HCC_POSTING_BIT] && !hcc_r.link_active) begin
                    hcc_r.write_posting_on <= 1'b0;
                end
                if (i_req.wdata[`HCC_LINK_ACTIVE_BIT]) begin
                    hcc_r.link_active <= 1'b0;
                end
            end
        end
    end

    // Self-ID base; low bits are not stored, which keeps 2K alignment by construction.
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst || si_flush) begin
            base_r <= '0;
        end else if (wr_base) begin
            base_r <= i_req.wdata[`SELFID_BASE_MSB:`SELFID_BASE_LSB];
        end
    end

    // Read image of the control register; unimplemented bits stay zero.
    always_comb begin
        hcc_rd = `ZERO_DATA;
        hcc_rd[`HCC_PERMIT_BIT] = permit_r;
        hcc_rd[`HCC_ENHANCE_BIT] = hcc_r.phy_enhance_on;
        hcc_rd[`HCC_POWER_STATE_BIT] = hcc_r.link_power_state;
        hcc_rd[`HCC_POSTING_BIT] = hcc_r.write_posting_on;
        hcc_rd[`HCC_LINK_ACTIVE_BIT] = hcc_r.link_active;
        hcc_rd[`HCC_SOFT_INIT_BIT] = si_busy;
    end

    // Answer one cycle after the request; a stopped PHY clock makes the
    // PHY-domain windows unreachable, so those end in abort, or in an ack with all-ones data on reads.
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            o_ack <= 1'b0;
            o_abort <= 1'b0;
            o_rdata <= `ZERO_DATA;
        end else begin
            o_ack <= 1'b0;
            o_abort <= 1'b0;
            o_rdata <= `ZERO_DATA;
            if (i_req_valid) begin
                if (in_phy_domain(i_req.addr) && !alive_r) begin
                    o_abort <= !i_suppress_abort;
                    o_ack <= i_suppress_abort;
                    if (!i_req.wr && i_suppress_abort) begin
                        o_rdata <= `ALL_ONES_DATA;
                    end
                end else begin
                    o_ack <= 1'b1;
                    if (!i_req.wr) begin
                        if (i_req.addr == `OFS_HCC_SET || i_req.addr == `OFS_HCC_CLR) begin
                            o_rdata <= hcc_rd;
                        end else if (i_req.addr == `OFS_SELFID_BASE) begin
                            o_rdata <= o_selfid_base;
                        end
                    end
                end
            end
        end
    end

    // Pointer and quadlet address toward the self-ID DMA writer.
    // aligned base
    assign o_selfid_base = {base_r, {`SELFID_BASE_LSB{1'b0}}};
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            o_selfid_wr_addr <= `ZERO_DATA;
        end else begin
            o_selfid_wr_addr <= o_selfid_base | {21'h000000, i_selfid_quad, 2'h0};
        end
    end

    // Control outputs straight from the register bits.
    // PHY traffic gate
    assign o_phy_comm_en = hcc_r.link_power_state;
    assign o_bus_connect = hcc_r.link_active;
    assign o_write_posting_on = hcc_r.write_posting_on;
    assign o_phy_enhance_on = hcc_r.phy_enhance_on;
    assign o_soft_init_flush = si_flush;

endmodule

// [verification/link_host_control_regs_props.sv]
`timescale 1ns/1ps

module link_host_control_regs_props
    import link_regs_pkg::*;
(
    input wire logic i_clk_sys, // Clock.
    input wire logic i_sys_rst, // Reset.
    input wire logic i_req_valid, // Access strobe.
    input wire reg_req_t i_req, // Access word.
    input wire logic o_ack, // Normal end.
    input wire logic o_abort, // Abort end.
    input wire logic [31:0] o_rdata, // Read data.
    input wire logic i_suppress_abort, // Abort suppression.
    input wire logic [8:0] i_selfid_quad, // Quadlet index.
    input wire logic [31:0] o_selfid_wr_addr, // Store address.
    input wire logic [31:0] o_selfid_base, // Buffer base.
    input wire logic o_phy_comm_en, // PHY traffic.
    input wire logic o_bus_connect, // On the bus.
    input wire logic o_write_posting_on, // Posting.
    input wire logic o_phy_enhance_on, // Enhancements.
    input wire logic o_soft_init_flush // Flush pulse.
);
    logic hcc_rd;
    logic hcc_set;
    logic base_wr;
    // Decoded accesses; a write that meets the flush cycle is left out, since the flush wins there.
    assign hcc_rd = i_req_valid && !i_req.wr && (i_req.addr == 12'h050 || i_req.addr == 12'h054);
    assign hcc_set = i_req_valid && i_req.wr && i_req.addr == 12'h050 && !o_soft_init_flush;
    assign base_wr = i_req_valid && i_req.wr && i_req.addr == 12'h064 && !o_soft_init_flush;

    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_sys_rst);

    a_answer_once: assert property (i_req_valid |=> o_ack != o_abort)
        else $error("access not answered exactly once");
    a_abort_cause: assert property (o_abort |-> $past(i_req_valid) && !$past(i_suppress_abort))
        else $error("abort without cause");
    a_hcc_reserved: assert property (hcc_rd |=> o_rdata[21:20] == 2'h0 && o_rdata[15:0] == 16'h0000)
        else $error("reserved control bits not zero");
    a_base_write: assert property (base_wr |=> o_selfid_base == {$past(i_req.wdata[31:11]), 11'h000})
        else $error("self id base not stored aligned");
    a_store_addr: assert property (1'b1 |=> o_selfid_wr_addr == ($past(o_selfid_base) | {21'h0, $past(i_selfid_quad), 2'b00}))
        else $error("self id store address wrong");
    a_posting_locked: assert property (o_bus_connect && !o_soft_init_flush |=> $stable(o_write_posting_on))
        else $error("posting changed while link active");
    a_enhance_gated: assert property ($rose(o_phy_enhance_on) |-> $past(o_bus_connect))
        else $error("enhancements on without link active");
    a_flush_clears: assert property (o_soft_init_flush |=> !o_bus_connect && !o_phy_comm_en && !o_write_posting_on
        && !o_phy_enhance_on && o_selfid_base == 32'h00000000)
        else $error("soft init left state behind");
    a_power_gate: assert property (hcc_set && i_req.wdata[19] |=> o_phy_comm_en)
        else $error("power state set not applied");
    a_link_drop: assert property (i_req_valid && i_req.wr && i_req.addr == 12'h054 && i_req.wdata[17] |=> !o_bus_connect)
        else $error("link stayed connected after clear");
endmodule

// [verification/host_bus_model.sv]
`timescale 1ns/1ps

module host_bus_model
    import link_regs_pkg::*;
#(
    parameter int SETTLE_CYCLES = 20
)
(
    input wire logic i_clk_sys, // Clock.
    output logic o_req_valid, // Access strobe.
    output reg_req_t o_req, // Access word.
    input wire logic i_ack, // Normal end.
    input wire logic i_abort, // Abort end.
    input wire logic [31:0] i_rdata // Read data.
);
    initial begin
        o_req_valid = 1'b0;
        o_req = '0;
    end

    // One access: strobe for one edge, take the answer in the cycle it stands.
    task automatic access(input logic wr, input logic [11:0] addr, input logic [31:0] wdata,
        output logic ack, output logic abt, output logic [31:0] rdata);
        @(negedge i_clk_sys);
        o_req_valid = 1'b1;
        o_req = '{wr: wr, addr: addr, wdata: wdata};
        @(negedge i_clk_sys);
        o_req_valid = 1'b0;
        ack = i_ack;
        abt = i_abort;
        rdata = i_rdata;
        // settle wait. The real wait is far longer; it is cut short to keep runs brief.
        if (wr && addr == 12'h050 && wdata[19]) begin
            repeat (SETTLE_CYCLES) @(negedge i_clk_sys);
        end
    endtask
endmodule

// [verification/link_host_control_regs_test.sv]
`timescale 1ns/1ps

module link_host_control_regs_test
    import link_regs_pkg::*;
;
    logic i_clk_sys = 1'b0;
    logic i_sys_rst = 1'b1;
    logic i_req_valid;
    reg_req_t i_req;
    logic i_suppress_abort = 1'b0;
    logic i_enhance_cfg_permit = 1'b1;
    logic i_phy_clk_alive = 1'b0;
    logic [8:0] i_selfid_quad = 9'h000;
    logic o_ack, o_abort, o_phy_comm_en, o_bus_connect, o_write_posting_on, o_phy_enhance_on, o_soft_init_flush;
    logic [31:0] o_rdata, o_selfid_wr_addr, o_selfid_base, rdat, d, rq;
    logic [31:0] seed = 32'h0C91C753;
    logic ack, abt, w_in, st_p, st_e, st_l, st_w, st_a;
    logic [11:0] win [6] = '{12'h0D8, 12'h0DC, 12'h0F0, 12'h100, 12'h11C, 12'h120};
    int err_total = 0;
    int checks = 0;
    int n;

    // Clock of 100 ns period.
    always #50 i_clk_sys = ~i_clk_sys;

    link_host_control_regs u_dut (.i_clk_sys, .i_sys_rst, .i_req_valid, .i_req, .o_ack, .o_abort, .o_rdata,
        .i_suppress_abort, .i_enhance_cfg_permit, .i_phy_clk_alive, .i_selfid_quad, .o_selfid_wr_addr,
        .o_selfid_base, .o_phy_comm_en, .o_bus_connect, .o_write_posting_on, .o_phy_enhance_on, .o_soft_init_flush);

    host_bus_model #(.SETTLE_CYCLES(20)) u_host (.i_clk_sys, .o_req_valid(i_req_valid), .o_req(i_req),
        .i_ack(o_ack), .i_abort(o_abort), .i_rdata(o_rdata));

    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // Expected control image from the bits the bench believes are set.
    function automatic logic [31:0] hcc_img(logic p, logic e, logic l, logic w, logic a, logic b);
        return {8'h00, p, e, 2'b00, l, w, a, b, 16'h0000};
    endfunction

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] wd);
        u_host.access(w, a, wd, ack, abt, rdat);
    endtask

    task automatic rd_hcc(input string what, input logic [11:0] a);
        acc(1'b0, a, 32'h00000000);
        chk(what, hcc_img(st_p, st_e, st_l, st_w, st_a, 1'b0), rdat);
    endtask

    task automatic final_report;
        $display("checks %0d err_total %0d", checks, err_total);
        if (err_total == 0 && checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // Random quadlet indexes keep the store address path busy all run.
    always @(negedge i_clk_sys) begin
        rq = xs();
        i_selfid_quad <= rq[8:0];
    end

    // Watchdog: the whole sequence needs well under a thousand cycles.
    initial begin
        repeat (3000) @(posedge i_clk_sys);
        err_total++;
        final_report;
    end

    initial begin
        st_p = 1'b1;
        {st_e, st_l, st_w, st_a} = 4'h0;
        repeat (5) @(posedge i_clk_sys);
        @(negedge i_clk_sys);
        i_sys_rst = 1'b0;
        // The permit pin needs two edges through its synchroniser before bit 23 reads back.
        repeat (2) @(negedge i_clk_sys);
        rd_hcc("hcc after reset", 12'h050);
        // Base writes: all ones first, then random words.
        for (int i = 0; i < 8; i++) begin
            d = (i == 0) ? 32'hFFFFFFFF : xs();
            acc(1'b1, 12'h064, d);
            acc(1'b0, 12'h064, 32'h00000000);
            chk("selfid base read", d & 32'hFFFFF800, rdat);
            chk("selfid base port", d & 32'hFFFFF800, o_selfid_base);
        end
        // Bring the link up in the order software must follow.
        acc(1'b1, 12'h050, 32'h00400000);
        rd_hcc("enhance refused idle", 12'h050);
        acc(1'b1, 12'h050, 32'h000C0000);
        {st_l, st_w} = 2'b11;
        acc(1'b1, 12'h050, 32'h00020000);
        st_a = 1'b1;
        acc(1'b1, 12'h054, 32'h00040000);
        acc(1'b1, 12'h050, 32'h00400000);
        st_e = 1'b1;
        rd_hcc("hcc link up", 12'h054);
        chk("control pins", 32'hF, {28'h0, o_phy_comm_en, o_bus_connect, o_write_posting_on, o_phy_enhance_on});
        // Permit withdrawn: a clear of the enhancement bit must be refused.
        i_enhance_cfg_permit = 1'b0;
        st_p = 1'b0;
        repeat (3) @(negedge i_clk_sys);
        acc(1'b1, 12'h054, 32'h00410000);
        rd_hcc("permit held enhance", 12'h050);
        i_enhance_cfg_permit = 1'b1;
        st_p = 1'b1;
        repeat (3) @(negedge i_clk_sys);
        acc(1'b1, 12'h054, 32'h00420000);
        acc(1'b1, 12'h054, 32'h000C0000);
        {st_e, st_l, st_w, st_a} = 4'h0;
        rd_hcc("hcc link down", 12'h050);
        chk("pins down", 32'h0, {28'h0, o_phy_comm_en, o_bus_connect, o_write_posting_on, o_phy_enhance_on});
        // PHY window with its clock stopped, both suppression settings, edges just outside.
        for (int i = 0; i < 12; i++) begin
            i_suppress_abort = i[0];
            acc(i[0] & i[1], win[i / 2], xs());
            w_in = (i > 1 && i < 10);
            chk("window answer", {30'h0, !w_in || i[0], w_in && !i[0]}, {30'h0, ack, abt});
            if (!(i[0] && i[1])) chk("window data", (w_in && i[0]) ? 32'hFFFFFFFF : 32'h0, rdat);
        end
        i_phy_clk_alive = 1'b1;
        repeat (3) @(negedge i_clk_sys);
        acc(1'b0, 12'h11C, 32'h00000000);
        chk("alive window", 32'h80000000, {ack, abt, rdat[29:0]});
        acc(1'b0, 12'h200, 32'h00000000);
        chk("unmapped read", 32'h80000000, {ack, abt, rdat[29:0]});
        // Soft init from an active link with power state and posting on, enhancements off.
        acc(1'b1, 12'h050, 32'h000C0000);
        acc(1'b1, 12'h050, 32'h00020000);
        acc(1'b1, 12'h050, 32'h00010000);
        chk("flush pulse", 32'h1, {31'h0, o_soft_init_flush});
        acc(1'b0, 12'h050, 32'h00000000);
        chk("soft init busy", hcc_img(st_p, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1), rdat);
        chk("flush ended", 32'h0, {31'h0, o_soft_init_flush});
        n = 0;
        do begin
            acc(1'b0, 12'h050, 32'h00000000);
            n++;
        end while (rdat[16] === 1'b1 && n < 20);
        chk("soft init done", hcc_img(st_p, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0), rdat);
        chk("base flushed", 32'h00000000, o_selfid_base);
        final_report;
    end
endmodule

bind link_host_control_regs link_host_control_regs_props u_props (.i_clk_sys, .i_sys_rst, .i_req_valid, .i_req,
    .o_ack, .o_abort, .o_rdata, .i_suppress_abort, .i_selfid_quad, .o_selfid_wr_addr, .o_selfid_base,
    .o_phy_comm_en, .o_bus_connect, .o_write_posting_on, .o_phy_enhance_on, .o_soft_init_flush);
